// file: core/irq_indirect_pkg.sv
/*
  Constants and carrier types for the interrupt-enable, tone-decoder status
  and indirect access register slice.
  Assumes a core clock of 40 MHz and a byte-wide register port from the
  control interface front end.
*/
package irq_indirect_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFF_MASK_ALARM_LOOP = 8'h16;
  localparam logic [7:0] OFF_MASK_MISC       = 8'h17;
  localparam logic [7:0] OFF_TONE_STATUS     = 8'h18;
  localparam logic [7:0] OFF_DATA_LOW        = 8'h1c;
  localparam logic [7:0] OFF_DATA_HIGH       = 8'h1d;
  localparam logic [7:0] OFF_LOCATION        = 8'h1e;
  localparam logic [7:0] OFF_XFER_STATUS     = 8'h1f;

  // ==========================================================================
  // Field positions and widths
  localparam int ALARM_LOOP_BITS   = 8;
  localparam int MISC_BITS         = 3;
  localparam int MISC_CAL_ERR_BIT  = 2;
  localparam int MISC_IND_DONE_BIT = 1;
  localparam int MISC_TONE_BIT     = 0;
  localparam int TONE_VALID_BIT    = 4;
  localparam int BUSY_BIT          = 0;
  localparam int WORD_BITS         = 16;
  localparam int LOC_BITS          = 8;
  localparam int MEM_DEPTH         = 256;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_MASK_ALARM_LOOP = 8'h00;
  localparam logic [2:0] RST_MASK_MISC       = 3'h0;
  localparam logic [7:0] RST_DATA_LOW        = 8'h00;
  localparam logic [7:0] RST_DATA_HIGH       = 8'h00;
  localparam logic [7:0] RST_LOCATION        = 8'h00;
  localparam logic [7:0] READ_ZERO           = 8'h00;

  // ==========================================================================
  // Timing: indirect memory update tick
  localparam int CLK_FREQ_HZ    = 40_000_000;
  localparam int UPDATE_RATE_HZ = 16_000;
  localparam int UPDATE_CYCLES  = CLK_FREQ_HZ / UPDATE_RATE_HZ;
  localparam int TICK_BITS      = 12;
  localparam logic [11:0] TICK_LAST = 12'(UPDATE_CYCLES - 1);

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    XFER_IDLE  = 3'b001,
    XFER_WRITE = 3'b010,
    XFER_READ  = 3'b100
  } xfer_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       present;
    logic [3:0] symbol;
  } tone_status_t;

endpackage

// file: core/irq_indirect_regs.sv
/*
  Interrupt enables, tone-decoder status and indirect register access port.
  Holds the event pending bits, the 256 x 16 indirect store and the 16 kHz
  update tick that services indirect transfers.
  Assumes the control interface front end delivers single-cycle read/write
  strobes at byte offsets, synchronous to clk, and that the tone decoder and
  event sources present synchronous levels and one-cycle event pulses.
*/
// Behaviour
// - Alarm/loop mask: alarms one to six in D2..D7, loop D1, ring trip D0.
// - Misc mask: calibration error bit 2, indirect done bit 1, tone bit 0.
// - Decoder status bit 4 shows a digit present; bits 7:5 read zero.
// - Digit code field 3:0 passes the decoder's keypad code unchanged.
// - Data then address write stores the data word at the next update tick.
// - Address-only write loads the data word from memory at next tick.
// - Data word is 16 bits over two byte registers, low resets to zero.
// - Location register is 8 bits read/write; host writes it before use.
// - Transfer status bit 0 is 1 while a transfer waits; bits 7:1 zero.
// - Completion of an indirect transfer sets the indirect-done pending bit.
// - Pending bits are 1 while pending; a 1 on the matching clear input clears them unless an event sets them in the same cycle.
`timescale 1ns/10ps
module irq_indirect_regs (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire irq_indirect_pkg::reg_req_t      req,
  output logic [7:0]                           rdata,
  input  wire irq_indirect_pkg::tone_status_t  tone,
  input  wire logic [7:0]                      alarm_loop_event,
  input  wire logic [2:0]                      misc_event,
  input  wire logic [7:0]                      alarm_loop_clear,
  input  wire logic [2:0]                      misc_clear,
  output logic [7:0]                           alarm_loop_pending,
  output logic [2:0]                           misc_pending,
  output logic                                 irq
);

  // ==========================================================================
  // Decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic wr_mask_al;
  logic wr_mask_misc;
  logic wr_low;
  logic wr_high;
  logic wr_loc;

  assign wr_mask_al   = req.wr && hit(req.addr, irq_indirect_pkg::OFF_MASK_ALARM_LOOP);
  assign wr_mask_misc = req.wr && hit(req.addr, irq_indirect_pkg::OFF_MASK_MISC);
  assign wr_low       = req.wr && hit(req.addr, irq_indirect_pkg::OFF_DATA_LOW);
  assign wr_high      = req.wr && hit(req.addr, irq_indirect_pkg::OFF_DATA_HIGH);
  assign wr_loc       = req.wr && hit(req.addr, irq_indirect_pkg::OFF_LOCATION);

  // ==========================================================================
  // Enable registers
  logic [7:0] mask_alarm_loop_q;
  logic [2:0] mask_misc_q;
  logic       power_alarm_six_irq_en;
  logic       power_alarm_one_irq_en;
  logic       loop_closure_irq_en;
  logic       ring_trip_irq_en;
  logic       calibration_error_irq_en;
  logic       indirect_done_irq_en;
  logic       tone_detect_irq_en;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_alarm_loop_q <= irq_indirect_pkg::RST_MASK_ALARM_LOOP;
    end else if (wr_mask_al) begin
      mask_alarm_loop_q <= req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_misc_q <= irq_indirect_pkg::RST_MASK_MISC;
    end else if (wr_mask_misc) begin
      mask_misc_q <= req.wdata[2:0];
    end
  end

  // Named views of the enable fields for the checks below; irq gates with the mask registers directly
  assign power_alarm_six_irq_en   = mask_alarm_loop_q[7];
  assign power_alarm_one_irq_en   = mask_alarm_loop_q[2];
  assign loop_closure_irq_en      = mask_alarm_loop_q[1];
  assign ring_trip_irq_en         = mask_alarm_loop_q[0];
  assign calibration_error_irq_en = mask_misc_q[irq_indirect_pkg::MISC_CAL_ERR_BIT];
  assign indirect_done_irq_en     = mask_misc_q[irq_indirect_pkg::MISC_IND_DONE_BIT];
  assign tone_detect_irq_en       = mask_misc_q[irq_indirect_pkg::MISC_TONE_BIT];

  // ==========================================================================
  // Update tick
  logic [11:0] tick_cnt_q;
  logic        tick;

  assign tick = (tick_cnt_q == irq_indirect_pkg::TICK_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 12'h000;
    end else if (tick) begin
      tick_cnt_q <= 12'h000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 12'h001;
    end
  end

  // ==========================================================================
  // Indirect transfer control
  logic [15:0]                   mem [irq_indirect_pkg::MEM_DEPTH];
  logic [7:0]                    data_low_q;
  logic [7:0]                    data_high_q;
  logic [7:0]                    indirect_location_reg;
  logic                          data_loaded_q;
  logic                          service;
  logic                          indirect_busy;
  logic [15:0]                   indirect_data_word;
  irq_indirect_pkg::xfer_state_t state_q;

  assign indirect_data_word = {data_high_q, data_low_q};
  assign indirect_busy      = (state_q != irq_indirect_pkg::XFER_IDLE);
  // A location written in the tick cycle itself waits for the following tick
  assign service            = indirect_busy && tick && !wr_loc;

  // Remembers whether data was written since the last location write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_loaded_q <= 1'b0;
    end else if (wr_loc) begin
      data_loaded_q <= 1'b0;
    end else if (wr_low || wr_high) begin
      data_loaded_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= irq_indirect_pkg::XFER_IDLE;
    end else begin
      case (state_q)
        irq_indirect_pkg::XFER_IDLE,
        irq_indirect_pkg::XFER_WRITE,
        irq_indirect_pkg::XFER_READ: begin
          if (wr_loc) begin
            state_q <= (data_loaded_q || wr_low || wr_high) ? irq_indirect_pkg::XFER_WRITE
                                                             : irq_indirect_pkg::XFER_READ;
          end else if (service) begin
            state_q <= irq_indirect_pkg::XFER_IDLE;
          end
        end
        default: begin
          state_q <= irq_indirect_pkg::XFER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      indirect_location_reg <= irq_indirect_pkg::RST_LOCATION;
    end else if (wr_loc) begin
      indirect_location_reg <= req.wdata;
    end
  end

  // Memory has no reset; its contents are owned by the host
  always_ff @(posedge clk) begin
    if (service && state_q == irq_indirect_pkg::XFER_WRITE) begin
      mem[indirect_location_reg] <= indirect_data_word;
    end
  end

  // A completing read overrides a host data write in the same cycle; the host
  // is expected to keep off the data bytes while busy is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_low_q  <= irq_indirect_pkg::RST_DATA_LOW;
      data_high_q <= irq_indirect_pkg::RST_DATA_HIGH;
    end else if (service && state_q == irq_indirect_pkg::XFER_READ) begin
      {data_high_q, data_low_q} <= mem[indirect_location_reg];
    end else begin
      if (wr_low) begin
        data_low_q <= req.wdata;
      end
      if (wr_high) begin
        data_high_q <= req.wdata;
      end
    end
  end

  // ==========================================================================
  // Pending bits and interrupt request
  logic [7:0] misc_set;
  logic [2:0] misc_hw_set;

  assign misc_hw_set = misc_event | {1'b0, service, 1'b0};
  assign misc_set    = {5'h00, misc_hw_set};

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_loop_pending <= 8'h00;
      misc_pending       <= 3'h0;
    end else begin
      alarm_loop_pending <= (alarm_loop_pending & ~alarm_loop_clear) | alarm_loop_event;
      misc_pending       <= (misc_pending & ~misc_clear) | misc_set[2:0];
    end
  end

  assign irq = |(alarm_loop_pending & mask_alarm_loop_q) | |(misc_pending & mask_misc_q);

  // ==========================================================================
  // Read path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= irq_indirect_pkg::READ_ZERO;
    end else if (req.rd) begin
      case (req.addr)
        irq_indirect_pkg::OFF_MASK_ALARM_LOOP: rdata <= mask_alarm_loop_q;
        irq_indirect_pkg::OFF_MASK_MISC:       rdata <= {5'h00, mask_misc_q};
        irq_indirect_pkg::OFF_TONE_STATUS:     rdata <= {3'h0, tone.present, tone.symbol};
        irq_indirect_pkg::OFF_DATA_LOW:        rdata <= data_low_q;
        irq_indirect_pkg::OFF_DATA_HIGH:       rdata <= data_high_q;
        irq_indirect_pkg::OFF_LOCATION:        rdata <= indirect_location_reg;
        irq_indirect_pkg::OFF_XFER_STATUS:     rdata <= {7'h00, indirect_busy};
        default:                               rdata <= irq_indirect_pkg::READ_ZERO;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  sequence loc_write_s;
    wr_loc;
  endsequence

  sequence tick_s;
    tick && !wr_loc;
  endsequence

  mask_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_mask_al |=> (mask_alarm_loop_q == $past(req.wdata)) && (power_alarm_six_irq_en == $past(req.wdata[7])))
    else $error("alarm/loop mask not stored");

  misc_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == irq_indirect_pkg::OFF_MASK_MISC |=> rdata[7:3] == 5'h00 && rdata[2:0] == $past(mask_misc_q))
    else $error("misc mask read wrong");

  tone_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == irq_indirect_pkg::OFF_TONE_STATUS
      |=> rdata == {3'h0, $past(tone.present), $past(tone.symbol)})
    else $error("tone status read wrong");

  busy_raise_a: assert property (@(posedge clk) disable iff (!rst_n)
    loc_write_s |=> indirect_busy)
    else $error("busy not raised after location write");

  busy_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    indirect_busy && !tick |=> indirect_busy)
    else $error("busy dropped before update tick");

  store_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick_s ##0 (state_q == irq_indirect_pkg::XFER_WRITE)
      |=> mem[$past(indirect_location_reg)] == $past(indirect_data_word) && !indirect_busy)
    else $error("indirect write not stored at tick");

  load_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick_s ##0 (state_q == irq_indirect_pkg::XFER_READ)
      |=> indirect_data_word == $past(mem[indirect_location_reg]))
    else $error("indirect read not loaded at tick");

  done_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    indirect_busy ##0 tick_s |=> misc_pending[irq_indirect_pkg::MISC_IND_DONE_BIT])
    else $error("indirect done pending not set");

  clear_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    alarm_loop_clear[0] && !alarm_loop_event[0] |=> !alarm_loop_pending[0])
    else $error("pending bit not cleared");

  irq_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    indirect_busy && tick && !wr_loc && indirect_done_irq_en && !wr_mask_misc |=> irq)
    else $error("interrupt not raised for enabled done");

  status_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == irq_indirect_pkg::OFF_XFER_STATUS |=> rdata[7:1] == 7'h00)
    else $error("status reserved bits not zero");

  // Per-source views are checked one by one so a dropped mask bit shows up
  alarm_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ring_trip_irq_en && alarm_loop_pending[0]) || (loop_closure_irq_en && alarm_loop_pending[1])
      || (power_alarm_one_irq_en && alarm_loop_pending[2]) || (power_alarm_six_irq_en && alarm_loop_pending[7])
      |-> irq)
    else $error("interrupt missing for enabled alarm or loop event");

  misc_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (calibration_error_irq_en && misc_pending[2]) || (tone_detect_irq_en && misc_pending[0]) |-> irq)
    else $error("interrupt missing for enabled misc event");

  irq_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    (alarm_loop_pending == 8'h00) && (misc_pending == 3'h0) |-> !irq)
    else $error("interrupt raised with nothing pending");

  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    alarm_loop_event[0] && alarm_loop_clear[0] |=> alarm_loop_pending[0])
    else $error("pending bit lost when set and clear coincide");

endmodule

// file: dv/irq_indirect_host.sv
/*
  Host processor model for the register port of the interrupt-enable and
  indirect access slice: byte writes, byte reads and indirect transfers.
  Assumes the bench supplies clk; requests change at the falling edge.
*/
`timescale 1ns/10ps
module irq_indirect_host (
  input  wire logic                   clk,
  output irq_indirect_pkg::reg_req_t  req
);
  // ==========================================================================
  // Bus cycles
  initial req = '0;

  task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    // Idle bus shows inverted values so a stale address never looks valid
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    cyc(1'b0, a, 8'h00);
  endtask

  // ==========================================================================
  // Indirect transfers: a write sends data bytes first, location last; a read sends the location alone
  task automatic ind_write(input logic [7:0] loc, input logic [15:0] w);
    wr(8'h1c, w[7:0]);
    wr(8'h1d, w[15:8]);
    wr(8'h1e, loc);
  endtask

  task automatic ind_read(input logic [7:0] loc);
    wr(8'h1e, loc);
  endtask
endmodule

// file: dv/irq_indirect_regs_tb_top.sv
/*
  Self-checking bench for the register slice: register map, tone status,
  pending bits with interrupt masking, and indirect transfers.
  Assumes the host model in irq_indirect_host.sv and a 40 MHz core clock.
*/
`timescale 1ns/10ps
module irq_indirect_regs_tb_top;
  logic                          clk = 1'b0;
  logic                          rst_n = 1'b0;
  irq_indirect_pkg::reg_req_t    req;
  logic [7:0]                    rdata;
  irq_indirect_pkg::tone_status_t tone = '0;
  logic [7:0]                    al_ev = '0;
  logic [2:0]                    mi_ev = '0;
  logic [7:0]                    al_clr = '0;
  logic [2:0]                    mi_clr = '0;
  logic [7:0]                    al_pend;
  logic [2:0]                    mi_pend;
  logic                          irq;
  logic                          rd_seen = 1'b0;
  logic [7:0]                    exp_q[$];
  int                            n_errors = 0;
  int                            check_count = 0;
  int                            cycles = 0;

  always #12.5 clk = ~clk;

  irq_indirect_host host (.clk(clk), .req(req));

  irq_indirect_regs uut (
    .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .tone(tone),
    .alarm_loop_event(al_ev), .misc_event(mi_ev), .alarm_loop_clear(al_clr),
    .misc_clear(mi_clr), .alarm_loop_pending(al_pend), .misc_pending(mi_pend), .irq(irq)
  );

  // ==========================================================================
  // Comparison, verdict and hang guard
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Ceiling covers four transfers of up to 2500 cycles plus register traffic
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      results();
    end
  end

  // ==========================================================================
  // Read monitor: every read result is matched to the oldest note
  always @(posedge clk) rd_seen <= req.rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0)
        check({8'h00, rdata}, 16'hdead);
      else
        check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    end
  end

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask

  // One-cycle pulses on the event and clear inputs, then settle
  task automatic pulse(input logic [7:0] ae, input logic [2:0] me, input logic [7:0] ac, input logic [2:0] mc);
    @(negedge clk);
    al_ev <= ae; mi_ev <= me; al_clr <= ac; mi_clr <= mc;
    @(negedge clk);
    al_ev <= '0; mi_ev <= '0; al_clr <= '0; mi_clr <= '0;
  endtask

  task automatic xfer(input logic wr_op, input logic [7:0] loc, input logic [15:0] w);
    int n;
    if (wr_op) host.ind_write(loc, w);
    else host.ind_read(loc);
    rd_exp(8'h1f, 8'h01);
    n = 0;
    while (mi_pend[1] !== 1'b1 && n < 2600) begin
      @(negedge clk);
      n++;
    end
    check(16'(n <= 2501), 16'h0001);
    check(16'(mi_pend[1]), 16'h0001);
    check(16'(irq), 16'h0001);
    rd_exp(8'h1f, 8'h00);
    pulse(8'h00, 3'b000, 8'h00, 3'b010);
    check({14'h0000, irq, mi_pend[1]}, 16'h0000);
  endtask

  // ==========================================================================
  // Main sequence
  logic [3:0]  codes[15] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
                             4'ha, 4'hb, 4'hc, 4'hd, 4'hf, 4'h0};
  logic [7:0]  v, m, loc_a;
  logic [2:0]  mv, mm;
  logic [15:0] da, dc;

  initial begin
    void'($urandom(32'hbc79bdd3));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    rd_exp(8'h16, 8'h00);
    rd_exp(8'h17, 8'h00);
    rd_exp(8'h1c, 8'h00);
    rd_exp(8'h1f, 8'h00);
    rd_exp(8'h20, 8'h00);
    host.wr(8'h18, 8'hff);
    host.wr(8'h1f, 8'hff);
    rd_exp(8'h18, 8'h00);
    rd_exp(8'h1f, 8'h00);
    foreach (codes[i]) begin
      @(negedge clk);
      tone <= '{present: i[0], symbol: codes[i]};
      rd_exp(8'h18, {3'b000, i[0], codes[i]});
    end
    for (int i = 0; i < 5; i++) begin
      v = 8'($urandom);
      m = (i == 0) ? 8'hff : 8'($urandom);
      mv = 3'($urandom);
      mm = (i == 0) ? 3'b111 : 3'($urandom);
      host.wr(8'h16, m);
      host.wr(8'h17, {5'b10101, mm});
      rd_exp(8'h16, m);
      rd_exp(8'h17, {5'b00000, mm});
      pulse(v, mv, 8'h00, 3'b000);
      check({5'h00, mv, v}, {5'h00, mi_pend, al_pend});
      check(16'(irq), 16'(|(v & m) | |(mv & mm)));
      pulse(v, mv, v, mv);
      check({5'h00, mv, v}, {5'h00, mi_pend, al_pend});
      pulse(8'h00, 3'b000, v, mv);
      check({4'h0, irq, mi_pend, al_pend}, 16'h0000);
    end
    host.wr(8'h17, 8'h02);
    loc_a = 8'($urandom) & 8'hfe;
    da = 16'($urandom);
    dc = 16'($urandom);
    host.wr(8'h1d, 8'h5a);
    rd_exp(8'h1d, 8'h5a);
    xfer(1'b1, loc_a, da);
    xfer(1'b1, 8'hff, dc);
    rd_exp(8'h1c, dc[7:0]);
    rd_exp(8'h1e, 8'hff);
    xfer(1'b0, loc_a, 16'h0000);
    rd_exp(8'h1c, da[7:0]);
    rd_exp(8'h1d, da[15:8]);
    xfer(1'b0, 8'hff, 16'h0000);
    rd_exp(8'h1c, dc[7:0]);
    rd_exp(8'h1d, dc[15:8]);
    rd_exp(8'h1e, 8'hff);
    repeat (3) @(negedge clk);
    check(16'(exp_q.size()), 16'h0000);
    results();
  end
endmodule
